// ===== hcs_pkg.sv
// Constants shared by the host control and status handshake block.
package hcs_pkg;
   // APB byte addresses of the register words
   localparam logic [7:0] ADDR_HOST_CMD = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CONFIG = 8'h08;
   localparam logic [7:0] ADDR_ERR_CODE = 8'h0C;
   localparam logic [7:0] ADDR_ERR_HIST = 8'h10;
   localparam int ADDR_W = 8;

   // Host command word bit positions
   localparam int HC_BATCH_RESET = 3;
   localparam int HC_START = 4;
   localparam int HC_STOP = 5;
   localparam int HC_DISC_SIGNAL = 6;
   localparam int HC_DISC_CLEAR = 7;
   localparam int HC_SWITCH_LO = 13;
   localparam int HC_ERR_CLEAR = 15;
   localparam int HC_GEN_LO = 16;
   localparam int GEN_CMD_W = 16;

   // Status word bit positions
   localparam int ST_READY = 0;
   localparam int ST_BATCH_DONE = 3;
   localparam int ST_RUNNING = 4;
   localparam int ST_DISC_STOP = 7;
   localparam int ST_SWITCH_LO = 13;
   localparam int ST_ERROR = 15;
   localparam int ST_EXT_LO = 16;
   localparam int EXT_IN_W = 12;
   localparam int LOG_CONDS = 2;

   // Configuration word bit positions
   localparam int CF_DISC_EN = 0;
   localparam int CF_SYNC_STOP = 1;
   localparam int CF_HIST_CLEAR = 2;
   localparam int CF_TRIG_LO = 3;

   // Reset values
   localparam logic [31:0] HOST_CMD_RST = 32'h0000_0000;
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

   // Error codes recorded as latest error
   localparam logic [15:0] ERR_SYNC_OVERRUN = 16'h2600;
   localparam logic [15:0] ERR_SYNC_SKIP = 16'h2601;
   localparam logic [15:0] ERR_SYNC_LOSS = 16'h2610;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam int HIST_W = 8;

   // Timing: clock and longest storage-side switch time
   localparam int CLK_PERIOD_NS = 25;
   localparam int SWITCH_MAX_US = 100;
   localparam int SWITCH_MAX_CYC = (SWITCH_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int SWITCH_CNT_W = 13;
endpackage

// ===== hcs_sync.sv
// Two flip-flop synchroniser for a bus of independent level bits.
`timescale 1ns/10ps
module hcs_sync #(
   parameter int WIDTH = 1
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   // First stage, read only by the second
   logic [WIDTH-1:0] meta;

   // Two stages, each bit crossing on its own
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule // hcs_sync

// ===== hcs_switch_timer.sv
// Storage-side switch sequencer for one logging condition, bounded in time.
`timescale 1ns/10ps
module hcs_switch_timer
   import hcs_pkg::*;
#(
   parameter int MAX_CYC = SWITCH_MAX_CYC
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic req_i,
   input wire logic trig_mode_i,
   input wire logic ack_i,
   output logic switch_o,
   output logic done_o
);
   logic req_prev; // Request level one cycle ago
   logic busy; // Switch in progress
   logic [SWITCH_CNT_W-1:0] cnt; // Cycles spent switching
   wire req_rise = req_i & ~req_prev;
   wire timeout = (cnt == SWITCH_CNT_W'(MAX_CYC - 1));

   // Start on request edge, finish on ack or at the time limit
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         req_prev <= 1'b0;
         busy <= 1'b0;
         cnt <= '0;
         switch_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         req_prev <= req_i;
         switch_o <= req_rise & trig_mode_i & ~busy;
         if (req_rise & trig_mode_i & ~busy) begin
            busy <= 1'b1;
            cnt <= '0;
         end else if (busy) begin
            // Forced completion keeps the 100 us bound even without ack
            if (ack_i | timeout) begin
               busy <= 1'b0;
            end
            cnt <= cnt + 1'b1;
         end
         // Flag follows completion, drops with the request
         if (!req_i) begin
            done_o <= 1'b0;
         end else if (busy & (ack_i | timeout)) begin
            done_o <= 1'b1;
         end
      end
   end
endmodule // hcs_switch_timer

// ===== hcs_top.sv
// Host handshake block: APB command and status words around the logic control.
// Operation
// R1 - Ready rises once control is ready
// R2 - Watchdog error drops ready, halts control
// R3 - Batch-reset done rises at finish, even error
// R4 - Batch-reset done drops with its command
// R5 - Running flag set by start request
// R6 - Running flag cleared at reset
// R7 - Stop request clears running; stop wins
// R8 - Disconnection stop flag clears running
// R9 - Configured sync overrun/loss errors stop logic
// R10 - Sync skip error always stops logic
// R11 - Disconnection signal falling while running stops
// R12 - Falling while stopped leaves flag low
// R13 - Clear request clears disconnection flag
// R14 - Start ignored while disconnection flag set
// R15 - Host clears flag before restarting
// R16 - Switch-complete flag per condition, trigger mode
// R17 - Storage switch finishes within 100 us
// R18 - Error flag rises on any error
// R19 - Error clear pulse clears flag, code
// R20 - History erased only when setting is one
// R21 - Twelve external inputs on consecutive bits
// R22 - Host leaves reserved bit positions alone
// R23 - General commands passed into logic
// R24 - Disconnection mode needs signal high to start
// R25 - Act once per request edge
`timescale 1ns/10ps
module hcs_top
   import hcs_pkg::*;
#(
   parameter int SWITCH_CYC = hcs_pkg::SWITCH_MAX_CYC
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [hcs_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic WDT_ERR_I,
   input wire logic [hcs_pkg::EXT_IN_W-1:0] EXT_IN_I,
   input wire logic RESET_DONE_I,
   input wire logic ERR_EVENT_I,
   input wire logic [15:0] ERR_CODE_I,
   input wire logic SYNC_OVERRUN_I,
   input wire logic SYNC_SKIP_I,
   input wire logic SYNC_LOSS_I,
   input wire logic [hcs_pkg::LOG_CONDS-1:0] SWITCH_ACK_I,
   output logic LOGIC_RUN_O,
   output logic BATCH_RESET_O,
   output logic [hcs_pkg::LOG_CONDS-1:0] SWITCH_O,
   output logic [hcs_pkg::GEN_CMD_W-1:0] GEN_CMD_O
);
   import hcs_pkg::*;

   // Overview: the host writes one command word and reads one status word.
   // Start, stop, clear, batch-reset and switch bits act on their edge, not their level, so a command
   // held high for many cycles is taken only once.
   // The error and disconnection flags, set by hardware and cleared by the host, give the set priority,
   // so an event landing in the clear cycle is never lost.
   // Software-visible state
   logic [31:0] host_cmd; // Host output bits
   logic [31:0] host_prev; // Host bits one cycle ago, for edges
   logic [31:0] config_word; // Mode settings
   logic ready; // Module ready
   logic batch_done; // Batch-reset complete flag
   logic running; // Logic running flag
   logic disc_flag; // Stop-at-disconnection flag
   logic err_flag; // Error flag
   logic [15:0] err_code; // Latest error code
   logic [HIST_W-1:0] err_hist; // Count of stored errors
   logic [LOG_CONDS-1:0] switch_done; // Switch-complete flags
   logic [EXT_IN_W-1:0] ext_in; // Synchronised external inputs
   logic wdt_err; // Synchronised watchdog error

   // Watchdog and external inputs arrive from other clock domains.
   // Each bit crosses on its own; the inputs are independent levels,
   // so no word-wide coherence is promised for the external inputs.
   // Pins from outside the clock domain pass two flops
   hcs_sync #(.WIDTH(EXT_IN_W + 1)) u_sync (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .async_i({WDT_ERR_I, EXT_IN_I}),
      .sync_o({wdt_err, ext_in})
   );

   // A write lands only in the cycle that PREADY is high, the same
   // cycle the master samples the answer, so each write applies once.
   // Unmapped addresses answer with PSLVERR and leave all state alone.
   // APB decode
   wire apb_access = PSEL & PENABLE & PREADY;
   wire apb_wr = apb_access & PWRITE;
   wire hit_cmd = (PADDR == ADDR_HOST_CMD);
   wire hit_status = (PADDR == ADDR_STATUS);
   wire hit_config = (PADDR == ADDR_CONFIG);
   wire hit_code = (PADDR == ADDR_ERR_CODE);
   wire hit_hist = (PADDR == ADDR_ERR_HIST);
   wire hit_any = hit_cmd | hit_status | hit_config | hit_code | hit_hist;

   // Settings act from the cycle after the write lands; changing
   // them while the logic runs is allowed but not advised.
   // Configuration fields
   wire disc_en = config_word[CF_DISC_EN];
   wire sync_stop = config_word[CF_SYNC_STOP];
   wire hist_clear = config_word[CF_HIST_CLEAR];
   wire [LOG_CONDS-1:0] trig_mode = config_word[CF_TRIG_LO +: LOG_CONDS];

   // Reserved bit positions are stored and read back but drive nothing.
   // Host bit levels; writes come from APB on this clock, so no synchroniser
   wire y_batch = host_cmd[HC_BATCH_RESET];
   wire y_disc = host_cmd[HC_DISC_SIGNAL];
   wire [LOG_CONDS-1:0] y_switch = host_cmd[HC_SWITCH_LO +: LOG_CONDS];

   // host_prev trails host_cmd by one cycle, so each bit change gives one
   // pulse, and rewriting an unchanged word gives none.
   // R25 edge detect
   wire [31:0] host_rise = host_cmd & ~host_prev;
   wire [31:0] host_fall = ~host_cmd & host_prev;
   wire start_rise = host_rise[HC_START];
   wire stop_rise = host_rise[HC_STOP];
   wire clear_rise = host_rise[HC_DISC_CLEAR];
   wire batch_rise = host_rise[HC_BATCH_RESET];
   wire disc_fall = host_fall[HC_DISC_SIGNAL];
   // R19 clear on the falling half of the clear pulse
   wire errclr_fall = host_fall[HC_ERR_CLEAR];

   // R11 disconnection stop while running
   wire disc_trip = disc_en & disc_fall & running;

   // R10 skip stops regardless of setting
   wire sync_halt = SYNC_SKIP_I | (sync_stop & (SYNC_OVERRUN_I | SYNC_LOSS_I));

   // A lost ready holds the logic stopped while the watchdog error
   // stays; a start request during that time is simply dropped.
   // Any reason to stop: R7, R11, R8, R9, R10, R2
   wire stop_cond = stop_rise | disc_trip | disc_flag | sync_halt | ~ready;

   // R14 R24 start only when not blocked
   wire start_ok = start_rise & ~disc_flag & (~disc_en | y_disc);

   // Only one code is kept; when several errors land together the
   // event input wins, then skip, then overrun, then signal loss.
   // Any error source, hardware events first
   wire sync_err = SYNC_OVERRUN_I | SYNC_SKIP_I | SYNC_LOSS_I;
   wire any_err = ERR_EVENT_I | sync_err;
   wire [15:0] new_code = ERR_EVENT_I ? ERR_CODE_I :
                          SYNC_SKIP_I ? ERR_SYNC_SKIP :
                          SYNC_OVERRUN_I ? ERR_SYNC_OVERRUN : ERR_SYNC_LOSS;

   // Each flag has one combinational next value and one flop, so the
   // priority of set over clear reads in one place.
   // Next values of the control flags
   logic next_running;
   logic next_disc_flag;
   logic next_batch_done;
   logic next_err_flag;

   // Running flag: stop beats start
   always_comb begin
      next_running = running;
      // R7 stop wins over a simultaneous start
      if (stop_cond) begin
         next_running = 1'b0;
      // R5 start request sets running
      end else if (start_ok) begin
         next_running = 1'b1;
      end
   end

   // The flag only means something with disconnection control on;
   // turning that setting off clears the flag at once.
   // Disconnection flag: a trip beats a clear
   always_comb begin
      next_disc_flag = disc_flag;
      // R11 set only on a trip while running
      if (disc_trip) begin
         next_disc_flag = 1'b1;
      // R13 clear request clears the flag
      end else if (clear_rise) begin
         next_disc_flag = 1'b0;
      end
      // R12 a fall while stopped never sets it
      if (!disc_en) begin
         next_disc_flag = 1'b0;
      end
   end

   // Completion shows only while the command stays high, so software
   // can wait for it before dropping the command.
   // Batch-reset complete flag
   always_comb begin
      next_batch_done = batch_done;
      // R4 drops with the command
      if (!y_batch) begin
         next_batch_done = 1'b0;
      // R3 set at finish, with or without error
      end else if (RESET_DONE_I) begin
         next_batch_done = 1'b1;
      end
   end

   // Clearing acts on the falling edge, after a full on-off pulse.
   // Error flag: a new error beats the clear
   always_comb begin
      next_err_flag = err_flag;
      // R18 any error raises the flag
      if (any_err) begin
         next_err_flag = 1'b1;
      // R19 clear pulse completed
      end else if (errclr_fall) begin
         next_err_flag = 1'b0;
      end
   end

   // Readback multiplexer
   // Status bits are live flags; nothing is latched on read.
   // R21 external inputs on bits 27:16
   wire [31:0] status_word = {4'h0, ext_in, err_flag, switch_done, 5'h00,
                              disc_flag, 2'b00, running, batch_done, 2'b00, ready};
   wire [31:0] read_mux = hit_cmd ? host_cmd :
                          hit_status ? status_word :
                          hit_config ? config_word :
                          hit_code ? {16'h0000, err_code} :
                          hit_hist ? {{(32 - HIST_W){1'b0}}, err_hist} : 32'h0000_0000;

   // Trade-off: one wait state on every access buys registered read
   // data and PREADY, so no path runs from PADDR straight to PRDATA.
   // Status reads show the flags as they stood in the access cycle.
   // APB answer: one wait state, registered data
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end else begin
         PREADY <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit_any;
         if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
            PRDATA <= read_mux;
         end
      end
   end

   // Whole-word writes only; with no byte strobes, software must
   // read, modify and write the command word to change one bit.
   // Software-written words
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         host_cmd <= HOST_CMD_RST;
         config_word <= CONFIG_RST;
      end else begin
         if (apb_wr & hit_cmd) begin
            host_cmd <= PWDATA;
         end
         if (apb_wr & hit_config) begin
            config_word <= PWDATA;
         end
      end
   end

   // Ready follows the synchronised watchdog level: it rises on the
   // first edge after reset and drops three edges after the pin rises.
   // Ready and control flags
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         host_prev <= HOST_CMD_RST;
         ready <= 1'b0;
         // R6 running cleared at power-on and host reset
         running <= 1'b0;
         disc_flag <= 1'b0;
         batch_done <= 1'b0;
      end else begin
         host_prev <= host_cmd;
         // R1 R2 ready after reset, gone on watchdog error
         ready <= ~wdt_err;
         running <= next_running;
         disc_flag <= next_disc_flag;
         batch_done <= next_batch_done;
      end
   end

   // The history is a saturating count of errors, not the errors
   // themselves; it stops at all ones rather than wrapping to zero.
   // Error flag, code and history
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         err_flag <= 1'b0;
         err_code <= ERR_NONE;
         err_hist <= '0;
      end else begin
         err_flag <= next_err_flag;
         if (any_err) begin
            err_code <= new_code;
         end else if (errclr_fall) begin
            err_code <= ERR_NONE;
         end
         // R20 history wiped only when the setting is one
         if (errclr_fall & hist_clear & ~any_err) begin
            err_hist <= '0;
         end else if (any_err & (err_hist != {HIST_W{1'b1}})) begin
            err_hist <= err_hist + 1'b1;
         end
      end
   end

   // Each condition has its own timer; a request raised while it is
   // busy is ignored until the current switch is done.
   // The time limit forces completion when no acknowledge comes.
   // R16 R17 one switch sequencer per logging condition
   genvar gi;
   generate
      for (gi = 0; gi < LOG_CONDS; gi++) begin : g_switch
         hcs_switch_timer #(.MAX_CYC(SWITCH_CYC)) u_timer (
            .CLK_I(CLK_I),
            .RST_I(RST_I),
            .req_i(y_switch[gi]),
            .trig_mode_i(trig_mode[gi]),
            .ack_i(SWITCH_ACK_I[gi]),
            .switch_o(SWITCH_O[gi]),
            .done_o(switch_done[gi])
         );
      end
   endgenerate

   // All outputs come from flops, so the logic side sees clean levels.
   // GEN_CMD_O lags the host word by one cycle, like the run flag.
   // Outputs toward the hardware logic
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         LOGIC_RUN_O <= 1'b0;
         BATCH_RESET_O <= 1'b0;
         GEN_CMD_O <= '0;
      end else begin
         LOGIC_RUN_O <= next_running;
         // Pulse once per command edge
         BATCH_RESET_O <= batch_rise;
         // R23 general commands into the logic
         GEN_CMD_O <= host_cmd[HC_GEN_LO +: GEN_CMD_W];
      end
   end
endmodule // hcs_top

// ===== hcs_assertions.sv
// Port-level checks for the host handshake block.
`timescale 1ns/10ps
module hcs_checker
   import hcs_pkg::*;
#(
   parameter int SWITCH_CYC = 8
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [hcs_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic WDT_ERR_I,
   input wire logic SYNC_OVERRUN_I,
   input wire logic SYNC_SKIP_I,
   input wire logic SYNC_LOSS_I,
   input wire logic LOGIC_RUN_O,
   input wire logic BATCH_RESET_O,
   input wire logic [hcs_pkg::LOG_CONDS-1:0] SWITCH_O,
   input wire logic [hcs_pkg::GEN_CMD_W-1:0] GEN_CMD_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   logic [31:0] host_q; // Shadow of host word
   logic [31:0] cfg_q; // Shadow of config word
   wire acc_w = PSEL && PENABLE && PREADY && PWRITE; // Write lands here
   wire cmd_wr = acc_w && (PADDR == ADDR_HOST_CMD);
   wire cfg_wr = acc_w && (PADDR == ADDR_CONFIG);
   // Shadows follow completed writes only
   always_ff @(posedge CLK_I) begin
      host_q <= RST_I ? HOST_CMD_RST : (cmd_wr ? PWDATA : host_q);
      cfg_q <= RST_I ? CONFIG_RST : (cfg_wr ? PWDATA : cfg_q);
   end
   a_run_needs_start: assert property ($rose(LOGIC_RUN_O) |-> host_q[HC_START] && !host_q[HC_STOP])
      else $error("run rose without start");
   a_stop_wins: assert property (cmd_wr && PWDATA[HC_STOP] && !host_q[HC_STOP] |=> ##1 !LOGIC_RUN_O)
      else $error("stop did not clear run");
   a_skip_stops: assert property (SYNC_SKIP_I |-> ##[1:2] !LOGIC_RUN_O)
      else $error("skip error left run");
   a_sync_cfg_stop: assert property ((SYNC_OVERRUN_I || SYNC_LOSS_I) && cfg_q[CF_SYNC_STOP] |-> ##[1:2] !LOGIC_RUN_O)
      else $error("sync error left run");
   a_wdt_stops: assert property (WDT_ERR_I [*4] |=> !LOGIC_RUN_O)
      else $error("watchdog left run");
   a_batch_rise: assert property (cmd_wr && PWDATA[HC_BATCH_RESET] && !host_q[HC_BATCH_RESET] |-> ##[1:2] BATCH_RESET_O)
      else $error("batch reset not issued");
   a_batch_once: assert property (BATCH_RESET_O |=> !BATCH_RESET_O)
      else $error("batch reset held");
   a_gen_copy: assert property (cmd_wr |=> ##[0:1] GEN_CMD_O == host_q[31:16])
      else $error("general commands differ");
   a_switch_mode: assert property ((SWITCH_O & ~cfg_q[CF_TRIG_LO +: LOG_CONDS]) == '0)
      else $error("switch outside trigger mode");
   c_run: cover property ($rose(LOGIC_RUN_O));
   c_batch: cover property (BATCH_RESET_O);
   c_switch: cover property (SWITCH_O != '0);
endmodule // hcs_checker

bind hcs_top hcs_checker #(.SWITCH_CYC(SWITCH_CYC)) chk_u (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .WDT_ERR_I(WDT_ERR_I), .SYNC_OVERRUN_I(SYNC_OVERRUN_I), .SYNC_SKIP_I(SYNC_SKIP_I),
   .SYNC_LOSS_I(SYNC_LOSS_I), .LOGIC_RUN_O(LOGIC_RUN_O), .BATCH_RESET_O(BATCH_RESET_O),
   .SWITCH_O(SWITCH_O), .GEN_CMD_O(GEN_CMD_O));

// ===== hcs_host_model.sv
// Host processor model: APB master driving the handshake block.
`timescale 1ns/10ps
module hcs_host_model
   import hcs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   output logic PSEL,
   output logic PENABLE,
   output logic PWRITE,
   output logic [hcs_pkg::ADDR_W-1:0] PADDR,
   output logic [31:0] PWDATA
);
   // Reserved host bits 2:0 and 12:8
   localparam logic [31:0] CMD_MASK = 32'hFFFF_E0F8;
   logic [31:0] rdat; // Last read data
   logic rerr; // Last error response
   // Idle bus from time zero
   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
   end
   // One transfer; answer taken only at the ready edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= (a == ADDR_HOST_CMD) ? (d & CMD_MASK) : d;
      @(posedge CLK_I);
      PENABLE <= 1'b1;
      do @(posedge CLK_I); while (PREADY !== 1'b1);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
endmodule // hcs_host_model

// ===== tb_host_control_status_handshake.sv
// Self-checking bench for the host handshake block.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_host_control_status_handshake;
   import hcs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic wdt = 1'b0; // Watchdog error level
   logic [11:0] ext_in = 12'h000;
   logic [5:0] ev = 6'h00; // Acks, batch done, loss, overrun, skip
   logic err_ev = 1'b0; // General error event pulse
   logic [15:0] ecode = 16'h0000; // Code offered with the event
   logic run, bres;
   logic [1:0] sw;
   logic [15:0] gen;
   int fails = 0;
   int n_tests = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   hcs_top #(.SWITCH_CYC(8)) dut_u (.CLK_I(clk), .RST_I(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WDT_ERR_I(wdt),
      .EXT_IN_I(ext_in), .RESET_DONE_I(ev[3]), .ERR_EVENT_I(err_ev), .ERR_CODE_I(ecode),
      .SYNC_OVERRUN_I(ev[1]), .SYNC_SKIP_I(ev[0]), .SYNC_LOSS_I(ev[2]), .SWITCH_ACK_I(ev[5:4]),
      .LOGIC_RUN_O(run), .BATCH_RESET_O(bres), .SWITCH_O(sw), .GEN_CMD_O(gen));
   hcs_host_model h_u (.CLK_I(clk), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));
   task automatic rd(input logic [7:0] a);
      h_u.xfer(1'b0, a, 32'h0000_0000);
      d = h_u.rdat;
   endtask
   // Host word write, then flags settle
   task automatic cmd(input logic [31:0] v);
      h_u.xfer(1'b1, ADDR_HOST_CMD, v);
      repeat (2) @(negedge clk);
   endtask
   // One-cycle event pulses
   task automatic fire(input logic [5:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h00;
      repeat (2) @(negedge clk);
   endtask
   task automatic t_reset;
      rd(ADDR_STATUS);
      `CHK(d[ST_READY], 1'b1)
      `CHK(run, 1'b0)
      rd(ADDR_CONFIG);
      `CHK(d, CONFIG_RST)
      rd(8'h14);
      `CHK({h_u.rerr, d}, {1'b1, 32'h0000_0000})
      $display("t_reset done");
   endtask
   task automatic t_run;
      cmd(32'h0000_0010);
      `CHK(run, 1'b1)
      cmd(32'h0000_0020);
      `CHK(run, 1'b0)
      cmd(32'h0000_0000);
      cmd(32'h0000_0030);
      `CHK(run, 1'b0)
      cmd(32'h0000_0000);
      $display("t_run done");
   endtask
   task automatic t_disc;
      h_u.xfer(1'b1, ADDR_CONFIG, 32'h0000_0001);
      cmd(32'h0000_0010);
      `CHK(run, 1'b0)
      cmd(32'h0000_0040);
      cmd(32'h0000_0050);
      `CHK(run, 1'b1)
      cmd(32'h0000_0010);
      rd(ADDR_STATUS);
      `CHK({run, d[ST_DISC_STOP]}, 2'b01)
      cmd(32'h0000_0040);
      cmd(32'h0000_0050);
      `CHK(run, 1'b0)
      cmd(32'h0000_00C0);
      rd(ADDR_STATUS);
      `CHK(d[ST_DISC_STOP], 1'b0)
      cmd(32'h0000_0050);
      `CHK(run, 1'b1)
      cmd(32'h0000_0060);
      cmd(32'h0000_0020);
      rd(ADDR_STATUS);
      `CHK(d[ST_DISC_STOP], 1'b0)
      h_u.xfer(1'b1, ADDR_CONFIG, 32'h0000_0000);
      $display("t_disc done");
   endtask
   task automatic t_sync;
      cmd(32'h0000_0010);
      fire(6'h01);
      rd(ADDR_STATUS);
      `CHK({run, d[ST_ERROR]}, 2'b01)
      cmd(32'h0000_0000);
      cmd(32'h0000_0010);
      fire(6'h02);
      `CHK(run, 1'b1)
      h_u.xfer(1'b1, ADDR_CONFIG, 32'h0000_0002);
      fire(6'h04);
      `CHK(run, 1'b0)
      rd(ADDR_ERR_CODE);
      `CHK(d[15:0], ERR_SYNC_LOSS)
      cmd(32'h0000_8000);
      cmd(32'h0000_0000);
      rd(ADDR_STATUS);
      `CHK(d[ST_ERROR], 1'b0)
      rd(ADDR_ERR_CODE);
      `CHK(d[15:0], ERR_NONE)
      rd(ADDR_ERR_HIST);
      `CHK(d[7:0] != 8'h00, 1'b1)
      h_u.xfer(1'b1, ADDR_CONFIG, 32'h0000_0004);
      fire(6'h01);
      cmd(32'h0000_8000);
      cmd(32'h0000_0000);
      rd(ADDR_ERR_HIST);
      `CHK(d[7:0], 8'h00)
      @(posedge clk);
      err_ev <= 1'b1;
      ecode <= 16'h1234;
      @(posedge clk);
      err_ev <= 1'b0;
      rd(ADDR_ERR_CODE);
      `CHK(d[15:0], 16'h1234)
      rd(ADDR_STATUS);
      `CHK(d[ST_ERROR], 1'b1)
      $display("t_sync done");
   endtask
   task automatic t_batch;
      cmd(32'h0000_0008);
      `CHK(bres, 1'b1)
      rd(ADDR_STATUS);
      `CHK(d[ST_BATCH_DONE], 1'b0)
      `CHK(bres, 1'b0)
      fire(6'h08);
      rd(ADDR_STATUS);
      `CHK(d[ST_BATCH_DONE], 1'b1)
      cmd(32'h0000_0000);
      rd(ADDR_STATUS);
      `CHK(d[ST_BATCH_DONE], 1'b0)
      $display("t_batch done");
   endtask
   task automatic t_switch;
      h_u.xfer(1'b1, ADDR_CONFIG, 32'h0000_0018);
      cmd(32'h0000_2000);
      `CHK(sw, 2'b01)
      repeat (12) @(negedge clk);
      rd(ADDR_STATUS);
      `CHK(d[ST_SWITCH_LO], 1'b1)
      cmd(32'h0000_0000);
      h_u.xfer(1'b1, ADDR_HOST_CMD, 32'h0000_4000);
      rd(ADDR_STATUS);
      `CHK(d[ST_SWITCH_LO + 1], 1'b0)
      fire(6'h20);
      rd(ADDR_STATUS);
      `CHK(d[ST_SWITCH_LO + 1], 1'b1)
      cmd(32'h0000_0000);
      $display("t_switch done");
   endtask
   task automatic t_io;
      @(posedge clk);
      ext_in <= 12'hA5C;
      repeat (4) @(negedge clk);
      rd(ADDR_STATUS);
      `CHK(d[27:16], 12'hA5C)
      cmd(32'hBEEF_0000);
      `CHK(gen, 16'hBEEF)
      cmd(32'h0000_0010);
      @(posedge clk);
      wdt <= 1'b1;
      repeat (6) @(negedge clk);
      rd(ADDR_STATUS);
      `CHK({run, d[ST_READY]}, 2'b00)
      $display("t_io done");
   endtask
   // Verdict and end of run
   task automatic summarize;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_run();
      t_disc();
      t_sync();
      t_batch();
      t_switch();
      t_io();
      summarize();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule // tb_host_control_status_handshake
